/* core/full_closed_gear.sv */
// External feedback gear, counters and Wishbone register file.
// Assumes a classic Wishbone master on MCLK_IN and quadrature pins.
//
// Notes on behaviour
// - Numerator 1..65535, defaults to one
// - Denominator 1..65535, defaults to one
// - Gear writes need unlock value 000F
// - New gear values apply after power-up
// - Convert external counts by numerator/denominator
// - Rotary encoder counts four per line
// - Cumulative external counter follows movement
// - Within-revolution position clears at index
// - Position direction follows polarity match
// - Motor and scaled counters advance proportionally
// - Polarity 0 up on CCW, 1 on CW
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module full_closed_gear
    import fcg_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic EXT_A_IN,
    input wire logic EXT_B_IN,
    input wire logic EXT_Z_IN,
    input wire logic MOT_A_IN,
    input wire logic MOT_B_IN
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [15:0] numer_q;
    logic [15:0] denom_q;
    logic [15:0] unlock_q;
    logic polar_q;
    logic [15:0] act_numer_q;
    logic [15:0] act_denom_q;
    logic act_polar_q;
    logic power_up_q;
    logic [31:0] ext_cum_q;
    logic [31:0] ext_pos_q;
    logic [31:0] mot_cum_q;
    logic [31:0] scaled_q;
    logic ext_step;
    logic ext_raw_up;
    logic ext_up;
    logic ext_index;
    logic mot_step;
    logic mot_up;
    logic sc_step;
    logic sc_up;
    logic req;
    logic wr;
    logic unlocked;
    logic restart;
    logic apply;
    logic [15:0] wr16_numer;
    logic [15:0] wr16_denom;
    logic [15:0] wr16_unlock;
    logic wr_numer;
    logic wr_denom;
    logic wr_polar;
    logic [31:0] rd_data;
    logic [31:0] status;

    // ------------------------------------------------------------
    // Pin decoders
    // ------------------------------------------------------------

    // External scale or rotary encoder, with reference mark
    quad_decoder ext_dec (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .a_in(EXT_A_IN),
        .b_in(EXT_B_IN),
        .z_in(EXT_Z_IN),
        .step_out(ext_step),
        .up_out(ext_raw_up),
        .index_out(ext_index)
    );

    // Motor encoder, no index needed here
    quad_decoder mot_dec (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .a_in(MOT_A_IN),
        .b_in(MOT_B_IN),
        .z_in(1'b0),
        .step_out(mot_step),
        .up_out(mot_up),
        .index_out()
    );

    // Polarity decides which raw sense counts up
    assign ext_up = ext_raw_up ^ act_polar_q;

    // ------------------------------------------------------------
    // Ratio conversion
    // ------------------------------------------------------------

    // External counts in motor encoder units
    gear_scaler scaler (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .clear_in(apply),
        .step_in(ext_step),
        .up_in(ext_up),
        .numer_in(act_numer_q),
        .denom_in(act_denom_q),
        .step_out(sc_step),
        .up_out(sc_up)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------

    // Request qualifiers and byte-lane merge
    assign req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
    assign wr = req & WB_WE_IN;
    assign unlocked = unlock_q == UNLOCK_KEY;
    assign wr16_numer = {WB_SEL_IN[1] ? WB_DAT_IN[15:8] : numer_q[15:8],
                         WB_SEL_IN[0] ? WB_DAT_IN[7:0] : numer_q[7:0]};
    assign wr16_denom = {WB_SEL_IN[1] ? WB_DAT_IN[15:8] : denom_q[15:8],
                         WB_SEL_IN[0] ? WB_DAT_IN[7:0] : denom_q[7:0]};
    assign wr16_unlock = {WB_SEL_IN[1] ? WB_DAT_IN[15:8] : unlock_q[15:8],
                          WB_SEL_IN[0] ? WB_DAT_IN[7:0] : unlock_q[7:0]};

    // Gear and polarity writes, refused while locked; gear writes also refused when zero
    assign wr_numer = wr & (WB_ADR_IN == ADR_NUMER) & unlocked
                      & (wr16_numer != 16'h0000);
    assign wr_denom = wr & (WB_ADR_IN == ADR_DENOM) & unlocked
                      & (wr16_denom != 16'h0000);
    assign wr_polar = wr & (WB_ADR_IN == ADR_POLAR) & unlocked
                      & WB_SEL_IN[0];

    // Restart stands in for a power cycle of the parameters
    assign restart = wr & (WB_ADR_IN == ADR_CTRL) & WB_SEL_IN[0]
                     & WB_DAT_IN[CTRL_RESTART_BIT];
    assign apply = power_up_q | restart;

    // Status shows the polarity now in force and the unlock state
    assign status = {30'h0, unlocked, act_polar_q};

    // Read multiplexer, unmapped offsets read zero
    assign rd_data = (WB_ADR_IN == ADR_NUMER) ? {16'h0, numer_q} :
                     (WB_ADR_IN == ADR_DENOM) ? {16'h0, denom_q} :
                     (WB_ADR_IN == ADR_UNLOCK) ? {16'h0, unlock_q} :
                     (WB_ADR_IN == ADR_POLAR) ? {31'h0, polar_q} :
                     (WB_ADR_IN == ADR_EXT_CUM) ? ext_cum_q :
                     (WB_ADR_IN == ADR_EXT_POS) ? ext_pos_q :
                     (WB_ADR_IN == ADR_MOT_CUM) ? mot_cum_q :
                     (WB_ADR_IN == ADR_SCALED) ? scaled_q :
                     (WB_ADR_IN == ADR_STATUS) ? status :
                     32'h0000_0000;

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------

    // One-cycle acknowledge with read data registered
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h0000_0000;
        end else begin
            WB_ACK_OUT <= req;
            WB_DAT_OUT <= req ? rd_data : WB_DAT_OUT;
        end
    end

    // ------------------------------------------------------------
    // Stored settings
    // ------------------------------------------------------------

    // Written gear and polarity values wait here until the next power-up
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            numer_q <= NUMER_RST;
            denom_q <= DENOM_RST;
            unlock_q <= UNLOCK_RST;
            polar_q <= POLAR_RST;
        end else begin
            if (wr_numer) begin
                numer_q <= wr16_numer;
            end
            if (wr_denom) begin
                denom_q <= wr16_denom;
            end
            if (wr & (WB_ADR_IN == ADR_UNLOCK)) begin
                unlock_q <= wr16_unlock;
            end
            if (wr_polar) begin
                polar_q <= WB_DAT_IN[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Settings in force
    // ------------------------------------------------------------

    // Power-up marker is high for the first cycle after reset
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            power_up_q <= 1'b1;
        end else begin
            power_up_q <= 1'b0;
        end
    end

    // Stored settings take effect only at power-up or restart
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            act_numer_q <= NUMER_RST;
            act_denom_q <= DENOM_RST;
            act_polar_q <= POLAR_RST;
        end else if (apply) begin
            act_numer_q <= numer_q;
            act_denom_q <= denom_q;
            act_polar_q <= polar_q;
        end
    end

    // ------------------------------------------------------------
    // Feedback counters
    // ------------------------------------------------------------

    // Cumulative external count, raw pulses
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ext_cum_q <= 32'h0000_0000;
        end else if (apply) begin
            ext_cum_q <= 32'h0000_0000;
        end else if (ext_step) begin
            ext_cum_q <= ext_up ? ext_cum_q + 32'h1 : ext_cum_q - 32'h1;
        end
    end

    // Within-revolution position, cleared by the index
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ext_pos_q <= 32'h0000_0000;
        end else if (apply | ext_index) begin
            ext_pos_q <= 32'h0000_0000;
        end else if (ext_step) begin
            ext_pos_q <= ext_up ? ext_pos_q + 32'h1 : ext_pos_q - 32'h1;
        end
    end

    // Cumulative motor count
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            mot_cum_q <= 32'h0000_0000;
        end else if (apply) begin
            mot_cum_q <= 32'h0000_0000;
        end else if (mot_step) begin
            mot_cum_q <= mot_up ? mot_cum_q + 32'h1 : mot_cum_q - 32'h1;
        end
    end

    // External position in motor units, tracks the motor count
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            scaled_q <= 32'h0000_0000;
        end else if (apply) begin
            scaled_q <= 32'h0000_0000;
        end else if (sc_step) begin
            scaled_q <= sc_up ? scaled_q + 32'h1 : scaled_q - 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    // Numerator in force is never zero
    chk_numer_nonzero: assert property (
        @(posedge MCLK_IN) disable iff (RESET_IN)
        numer_q != 16'h0000 && act_numer_q != 16'h0000)
        else $error("numerator reached zero");

    // Denominator in force is never zero
    chk_denom_nonzero: assert property (
        @(posedge MCLK_IN) disable iff (RESET_IN)
        denom_q != 16'h0000 && act_denom_q != 16'h0000)
        else $error("denominator reached zero");

    // Locked writes leave the gear untouched
    chk_locked_gear: assert property (
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (wr && unlock_q != UNLOCK_KEY)
        |=> $stable(numer_q) && $stable(denom_q) && $stable(polar_q))
        else $error("gear changed while locked");

    // Settings in force move only on power-up or restart
    chk_apply_only: assert property (
        @(posedge MCLK_IN) disable iff (RESET_IN)
        !apply |=> $stable(act_numer_q) && $stable(act_denom_q))
        else $error("gear in force changed without power-up");

    // Polarity in force follows the same rule
    chk_polar_apply: assert property (
        @(posedge MCLK_IN) disable iff (RESET_IN)
        !apply |=> $stable(act_polar_q))
        else $error("polarity changed without power-up");

    // Each external up count raises the cumulative counter by one
    chk_ext_count: assert property (
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (ext_step && !apply && ext_up) |=> ext_cum_q == $past(ext_cum_q) + 32'h1)
        else $error("cumulative count missed a pulse");

    // Index clears the position in the next cycle
    chk_index_clear: assert property (
        @(posedge MCLK_IN) disable iff (RESET_IN)
        ext_index |=> ext_pos_q == 32'h0000_0000)
        else $error("index did not clear the position");

    // Down count with no index lowers position by one
    chk_pos_down: assert property (
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (ext_step && !ext_up && !ext_index && !apply)
        |=> ext_pos_q == $past(ext_pos_q) - 32'h1)
        else $error("position moved the wrong way");

    // Raw sense against polarity in force decides the position direction
    chk_polar_sense: assert property (
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (ext_step && !ext_index && !apply && (ext_raw_up != act_polar_q))
        |=> ext_pos_q == $past(ext_pos_q) + 32'h1)
        else $error("polarity sense wrong");

    // With a 1:1 gear one up count gives one unit two cycles on
    chk_unit_ratio: assert property (
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (ext_step && ext_up && !apply && act_numer_q == act_denom_q)
        ##1 !apply |=> scaled_q == $past(scaled_q) + 32'h1)
        else $error("unit ratio not followed");

    // Bus answer lasts one cycle
    chk_ack_pulse: assert property (
        @(posedge MCLK_IN) disable iff (RESET_IN)
        WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("acknowledge held too long");
endmodule

/* shared/fcg_pkg.sv */
// Constants shared by the external feedback gear block.
// Assumes a 125 MHz single clock and a byte-addressed Wishbone map.
package fcg_pkg;

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_NUMER = 8'h00;
    localparam logic [7:0] ADR_DENOM = 8'h04;
    localparam logic [7:0] ADR_UNLOCK = 8'h08;
    localparam logic [7:0] ADR_POLAR = 8'h0C;
    localparam logic [7:0] ADR_CTRL = 8'h10;
    localparam logic [7:0] ADR_EXT_CUM = 8'h14;
    localparam logic [7:0] ADR_EXT_POS = 8'h18;
    localparam logic [7:0] ADR_MOT_CUM = 8'h1C;
    localparam logic [7:0] ADR_SCALED = 8'h20;
    localparam logic [7:0] ADR_STATUS = 8'h24;

    // ------------------------------------------------------------
    // Values after reset and keys
    // ------------------------------------------------------------
    localparam logic [15:0] NUMER_RST = 16'h0001;
    localparam logic [15:0] DENOM_RST = 16'h0001;
    localparam logic [15:0] UNLOCK_RST = 16'h0000;
    localparam logic [15:0] UNLOCK_KEY = 16'h000F;
    localparam logic POLAR_RST = 1'b0;
    localparam int CTRL_RESTART_BIT = 0;
    localparam int STAT_POLAR_BIT = 0;
    localparam int STAT_UNLOCK_BIT = 1;
    localparam int REM_W = 25;

endpackage

/* core/quad_decoder.sv */
// Quadrature decoder with reference mark edge detect.
// Assumes A, B and Z arrive from pins, asynchronous to the clock.
`timescale 1ns/1ns
module quad_decoder
    import fcg_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic a_in,
    input wire logic b_in,
    input wire logic z_in,
    output logic step_out,
    output logic up_out,
    output logic index_out
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [2:0] prev_q;
    logic moved;

    // Two-stage synchroniser, then one stage of history
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
            prev_q <= 3'h0;
        end else begin
            meta_q <= {z_in, b_in, a_in};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Every single-bit A/B change is one count: four per line
    assign moved = (sync_q[0] ^ prev_q[0]) ^ (sync_q[1] ^ prev_q[1]);
    assign step_out = moved;
    assign up_out = prev_q[0] ^ sync_q[1];
    assign index_out = sync_q[2] & ~prev_q[2];
endmodule

/* core/gear_scaler.sv */
// Converts external encoder counts to motor encoder units.
// Assumes numerator and denominator are nonzero and stable.
`timescale 1ns/1ns
module gear_scaler
    import fcg_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clear_in,
    input wire logic step_in,
    input wire logic up_in,
    input wire logic [15:0] numer_in,
    input wire logic [15:0] denom_in,
    output logic step_out,
    output logic up_out
);
    logic signed [REM_W-1:0] rem_q;
    logic signed [REM_W-1:0] rem_d;
    logic signed [REM_W-1:0] num_s;
    logic signed [REM_W-1:0] den_s;
    logic signed [REM_W-1:0] sum;
    logic over;
    logic under;

    // Each up count adds numer, each down count subtracts it; each denom removed is one motor unit
    assign num_s = $signed({9'h000, numer_in});
    assign den_s = $signed({9'h000, denom_in});
    assign sum = rem_q + (step_in ? (up_in ? num_s : -num_s) : '0);
    assign over = sum >= den_s;
    assign under = sum <= -den_s;
    assign rem_d = over ? sum - den_s : (under ? sum + den_s : sum);

    // Remainder carried forward so no drift builds up
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rem_q <= '0;
            step_out <= 1'b0;
            up_out <= 1'b0;
        end else begin
            rem_q <= clear_in ? '0 : rem_d;
            step_out <= ~clear_in & (over | under);
            up_out <= over;
        end
    end
endmodule

/* bench/enc_model.sv */
// Behavioural quadrature encoder with reference mark output.
// Assumes the bench calls its tasks and owns the clock it follows.
`timescale 1ns/1ns
module enc_model (
    input wire logic clk_in,
    output logic a_out,
    output logic b_out,
    output logic z_out
);
    // ------------------------------------------------------------
    // Line phase and pin levels
    // ------------------------------------------------------------
    logic [1:0] phase_q;

    // Lines rest low with the encoder standing still
    initial begin
        phase_q = 2'h0;
        a_out = 1'b0;
        b_out = 1'b0;
        z_out = 1'b0;
    end

    // One Gray step per call turn, four per line, pins change after an edge
    task automatic move(input int n, input logic up, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            phase_q = up ? phase_q + 2'h1 : phase_q - 2'h1;
            a_out <= phase_q[1];
            b_out <= phase_q[1] ^ phase_q[0];
            repeat (gap) @(posedge clk_in);
        end
    endtask

    // Reference mark pulse, two cycles wide, with the lines held still
    task automatic mark();
        @(posedge clk_in);
        z_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        z_out <= 1'b0;
    endtask
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the external feedback gear block.
// Assumes one 125 MHz clock and encoder models on both feedback inputs.
`timescale 1ns/1ns
module tb_top;
    import fcg_pkg::*;

    // ------------------------------------------------------------
    // Signals, counters and expected-value queue
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst, cyc, stb, we, ack, ext_a, ext_b, ext_z, mot_a, mot_b;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dwr, drd, rnd, nv, mv;
    logic [31:0] exp_q[$];
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;

    always #4 mclk = ~mclk;

    full_closed_gear i_dut (.MCLK_IN(mclk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dwr), .WB_DAT_OUT(drd),
        .WB_ACK_OUT(ack), .EXT_A_IN(ext_a), .EXT_B_IN(ext_b), .EXT_Z_IN(ext_z),
        .MOT_A_IN(mot_a), .MOT_B_IN(mot_b));
    enc_model i_ext (.clk_in(mclk), .a_out(ext_a), .b_out(ext_b), .z_out(ext_z));
    enc_model i_mot (.clk_in(mclk), .a_out(mot_a), .b_out(mot_b), .z_out());

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task final_report();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task tend(input string name);
        $display("test %s done", name);
    endtask

    // Classic single cycle, held until ack is sampled high
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dwr <= d;
        // Ack ends this wait; if it never comes, only the bench timeout does
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(a, 1'b1, d);
    endtask

    // Notes the expected read value, the monitor compares it
    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(a, 1'b0, 32'h0);
    endtask

    // Power-up through the control register, then counters settle
    task restart();
        wr(ADR_CTRL, 32'h1 << CTRL_RESTART_BIT);
        repeat (3) @(posedge mclk);
    endtask

    // ------------------------------------------------------------
    // Monitor of read answers and timeout
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("read answer with nothing expected at t=%0t", $time);
            end else begin
                check(drd, exp_q.pop_front());
            end
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        dwr = 32'h0;
        rnd = 32'hF616;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        rd(ADR_NUMER, 32'h1);
        rd(ADR_DENOM, 32'h1);
        rd(ADR_STATUS, 32'h0);
        rd(8'h28, 32'h0);
        tend("reset values");
        wr(ADR_NUMER, 32'h3);
        rd(ADR_NUMER, 32'h1);
        wr(ADR_UNLOCK, {16'h0, UNLOCK_KEY});
        // Full closed mode is taken as already selected; ratio kept in range
        wr(ADR_NUMER, 32'h3);
        wr(ADR_DENOM, 32'h2);
        // Low lane only: the high byte must be left alone
        sel <= 4'h1;
        wr(ADR_DENOM, 32'hFF02);
        sel <= 4'hF;
        wr(ADR_NUMER, 32'h0);
        rd(ADR_NUMER, 32'h3);
        rd(ADR_DENOM, 32'h2);
        rd(ADR_STATUS, 32'h2);
        tend("unlock and range");
        i_ext.move(8, 1'b1, 2);
        repeat (40) @(posedge mclk);
        rd(ADR_EXT_CUM, 32'h8);
        rd(ADR_SCALED, 32'h8);
        rd(ADR_EXT_POS, 32'h8);
        restart();
        rd(ADR_EXT_CUM, 32'h0);
        tend("deferred gear");
        rnd = lfsr(rnd);
        nv = 32'(rnd[3:0]) + 32'h1;
        i_ext.move(int'(nv), 1'b1, int'(rnd[5:4]) + 1);
        repeat (60) @(posedge mclk);
        rd(ADR_SCALED, nv * 32'h3 / 32'h2);
        rd(ADR_EXT_CUM, nv);
        i_ext.move(1, 1'b1, 2);
        repeat (20) @(posedge mclk);
        rd(ADR_SCALED, (nv + 32'h1) * 32'h3 / 32'h2);
        i_ext.mark();
        repeat (10) @(posedge mclk);
        rd(ADR_EXT_POS, 32'h0);
        rd(ADR_EXT_CUM, nv + 32'h1);
        // Motor moves as far as the 3:2 gear says the scale did
        rnd = lfsr(rnd);
        mv = (nv + 32'h1) * 32'h3 / 32'h2;
        i_mot.move(int'(mv), 1'b1, int'(rnd[6:5]) + 1);
        repeat (20) @(posedge mclk);
        rd(ADR_MOT_CUM, mv);
        rd(ADR_SCALED, mv);
        tend("scaling and index");
        wr(ADR_POLAR, 32'h1);
        rd(ADR_STATUS, 32'h2);
        restart();
        rd(ADR_STATUS, 32'h3);
        i_ext.move(4, 1'b1, 2);
        repeat (20) @(posedge mclk);
        rd(ADR_EXT_POS, 32'hFFFFFFFC);
        i_ext.move(6, 1'b0, 1);
        repeat (20) @(posedge mclk);
        rd(ADR_EXT_POS, 32'h2);
        wr(ADR_UNLOCK, 32'h0);
        rd(ADR_STATUS, 32'h1);
        tend("polarity");
        repeat (4) @(posedge mclk);
        final_report();
    end
endmodule
